// File: hdl/ohc_pkg.sv
/*
 * Package for the operating hours counter block: widths, timing constants,
 * register map, reset values and the carrier types shared by the design.
 * Assumes a single 25 MHz system clock and an APB master on that clock.
 */
package ohc_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------

	// Number of independent counter instances.
	localparam int unsigned OHC_NUM = 4;
	// Minute count width: 100 years of minutes fits in 26 bits.
	localparam int unsigned OHC_MIN_W = 26;
	// Hours width: 100 years of hours fits in 20 bits.
	localparam int unsigned OHC_HRS_W = 20;
	// Setpoint width in hours, as a 32-bit operand word.
	localparam int unsigned OHC_SET_W = 32;
	// Prescaler width, large enough for one minute of clock cycles.
	localparam int unsigned OHC_PRE_W = 31;
	// Width of the event field in the status register.
	localparam int unsigned OHC_EV_W = 8;
	// APB address and data widths.
	localparam int unsigned OHC_AW = 8;
	localparam int unsigned OHC_DW = 32;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------

	// System clock rate in hertz.
	localparam longint unsigned OHC_CLK_HZ = 25_000_000;
	// Basic counting period in seconds.
	localparam longint unsigned OHC_TICK_S = 60;
	// Clock cycles in one counting period.
	localparam longint unsigned OHC_TICK_CYCLES = OHC_CLK_HZ * OHC_TICK_S;
	// Minutes in one hour, the divisor for the hours value.
	localparam logic [OHC_MIN_W-1:0] OHC_MIN_PER_HOUR = 26'h000003C;
	// Saturation value of the minute count: the last minute whose hours fit.
	localparam logic [OHC_MIN_W-1:0] OHC_MIN_MAX = 26'h3BFFFFF;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------

	// Spacing of the per-instance register groups.
	localparam logic [OHC_AW-1:0] OHC_INST_STRIDE = 8'h10;
	// Offsets inside one instance group.
	localparam logic [3:0] OHC_OFS_HOURS = 4'h0;
	localparam logic [3:0] OHC_OFS_MINUTES = 4'h4;
	localparam logic [3:0] OHC_OFS_SETPOINT = 4'h8;
	// Global registers.
	localparam logic [OHC_AW-1:0] OHC_ADDR_CTRL = 8'h40;
	localparam logic [OHC_AW-1:0] OHC_ADDR_STATUS = 8'h44;
	localparam logic [OHC_AW-1:0] OHC_ADDR_MASK = 8'h48;
	// Last address of the instance groups.
	localparam logic [OHC_AW-1:0] OHC_INST_END = 8'h3F;
	// Reset values.
	localparam logic [OHC_NUM-1:0] OHC_CTRL_RST = 4'hF;
	localparam logic [OHC_EV_W-1:0] OHC_MASK_RST = 8'h00;
	// Status layout: limit events low, clear events high.
	localparam int unsigned OHC_EV_LIMIT_LSB = 0;
	localparam int unsigned OHC_EV_CLEAR_LSB = 4;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------

	// Phase of the block: restore retained counts, then run.
	typedef enum logic [1:0] {
		OHC_RESTORE = 2'h0,
		OHC_RUN = 2'h1
	} ohc_phase_t;

	// APB request from the master.
	typedef struct packed {
		logic [OHC_AW-1:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [OHC_DW-1:0] pwdata;
	} ohc_apb_req_t;

	// APB answer to the master.
	typedef struct packed {
		logic [OHC_DW-1:0] prdata;
		logic pready;
		logic pslverr;
	} ohc_apb_rsp_t;

	// One group of minute counts, one word per instance.
	typedef logic [OHC_NUM-1:0][OHC_MIN_W-1:0] ohc_min_arr_t;
	// Hours values of all instances.
	typedef logic [OHC_NUM-1:0][OHC_HRS_W-1:0] ohc_hrs_arr_t;
	// Setpoints of all instances.
	typedef logic [OHC_NUM-1:0][OHC_SET_W-1:0] ohc_set_arr_t;
	// Prescalers of all instances.
	typedef logic [OHC_NUM-1:0][OHC_PRE_W-1:0] ohc_pre_arr_t;

	// Whole state of the block.
	typedef struct packed {
		ohc_phase_t phase;
		ohc_min_arr_t minutes;
		ohc_pre_arr_t prescale;
		ohc_hrs_arr_t hours;
		logic [OHC_NUM-1:0] contact;
		logic [OHC_NUM-1:0] clr_prev;
		logic [OHC_NUM-1:0] ctrl;
		logic [OHC_EV_W-1:0] status;
		logic [OHC_EV_W-1:0] mask;
		logic irq;
		logic [OHC_DW-1:0] rdata;
	} ohc_state_t;

endpackage

// File: hdl/ohc_top.sv
/*
 * Operating hours counter block with four instances, retained minute
 * counts, a limit contact per instance, and an APB register slave with
 * a masked, read-to-clear event interrupt.
 * Assumes the user logic and the retained store run on clk, and that the
 * store presents its saved counts whenever the block leaves reset.
 */
// Decided for this implementation: the register addresses and the APB register port.
// What this block does
// [RQ1] Enabled counters add one each minute tick
// [RQ2] Value output shows whole hours, truncated
// [RQ3] Minute counts kept in retained storage
// [RQ4] Clear input sets actual value to zero
// [RQ5] Limit contact while hours reach setpoint
// [RQ6] Reset, mode or program changes keep counts
// [RQ7] Partial minute dropped when enable falls
// [RQ8] Count range covers one hundred years
// [RQ9] User logic supplies setpoint in hours
// [RQ10] Four independent counter instances provided
// [RQ11] Minute prescaler runs only while enabled
// [RQ12] Clear overrides enable when both active
`timescale 1ns/10ps
`default_nettype none

module ohc_top
#(
	// Clock cycles per minute tick; shorten for simulation.
	parameter int unsigned MINUTE_CYCLES = 32'(ohc_pkg::OHC_TICK_CYCLES)
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic [ohc_pkg::OHC_NUM-1:0] hours_count_enable,
	input wire logic [ohc_pkg::OHC_NUM-1:0] hours_clear_input,
	input wire ohc_pkg::ohc_set_arr_t upper_hours_setpoint,
	output logic [ohc_pkg::OHC_NUM-1:0] limit_reached_contact,
	output ohc_pkg::ohc_hrs_arr_t hours_value_output,
	input wire ohc_pkg::ohc_min_arr_t retained_minutes_in,
	output ohc_pkg::ohc_min_arr_t retained_minutes_out,
	output logic retained_valid,
	input wire ohc_pkg::ohc_apb_req_t apb_req,
	output ohc_pkg::ohc_apb_rsp_t apb_rsp,
	output logic irq
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// Last prescaler value before a minute tick.
	localparam logic [ohc_pkg::OHC_PRE_W-1:0] TICK_LAST =
		ohc_pkg::OHC_PRE_W'(MINUTE_CYCLES - 1);

	// Tells whether an address falls on a mapped register.
	function automatic logic ohc_mapped(input logic [ohc_pkg::OHC_AW-1:0] a);
		logic [3:0] ofs;
		ofs = a[3:0];
		if (a <= ohc_pkg::OHC_INST_END)
		begin
			ohc_mapped = (ofs == ohc_pkg::OHC_OFS_HOURS) ||
				(ofs == ohc_pkg::OHC_OFS_MINUTES) ||
				(ofs == ohc_pkg::OHC_OFS_SETPOINT);
		end
		else
		begin
			ohc_mapped = (a == ohc_pkg::OHC_ADDR_CTRL) ||
				(a == ohc_pkg::OHC_ADDR_STATUS) ||
				(a == ohc_pkg::OHC_ADDR_MASK);
		end
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------

	// Registered state of the whole block.
	ohc_pkg::ohc_state_t st;
	// Next value of the state.
	ohc_pkg::ohc_state_t next_st;
	// APB phase decodes.
	logic apb_setup;
	logic apb_access;
	// Effective enable per instance, coil gated by the control register.
	logic [ohc_pkg::OHC_NUM-1:0] cnt_en;

	// Phase decodes of the APB transfer.
	assign apb_setup = apb_req.psel & ~apb_req.penable;
	assign apb_access = apb_req.psel & apb_req.penable;

	// Counting is allowed only where software leaves the instance on.
	assign cnt_en = hours_count_enable & st.ctrl;

	// Computes the next state of counters, events and registers.
	always_comb
	begin
		logic [ohc_pkg::OHC_EV_W-1:0] ev;
		logic [ohc_pkg::OHC_EV_W-1:0] rd_clr;
		logic [3:0] ofs;
		int unsigned idx;
		ev = '0;
		rd_clr = '0;
		ofs = apb_req.paddr[3:0];
		idx = 32'(apb_req.paddr[5:4]);
		next_st = st;

		// Counter instances, each fully independent. [RQ10]
		for (int i = 0; i < ohc_pkg::OHC_NUM; i++)
		begin
			if (st.phase == ohc_pkg::OHC_RESTORE)
			begin
				// Counts resume from the retained store. [RQ3] [RQ6]
				next_st.minutes[i] = retained_minutes_in[i];
				next_st.prescale[i] = '0;
			end
			else if (hours_clear_input[i])
			begin
				// Clear wins over enable and holds zero. [RQ4] [RQ12]
				next_st.minutes[i] = '0;
				next_st.prescale[i] = '0;
			end
			else if (!cnt_en[i])
			begin
				// Seconds of a broken minute are dropped. [RQ7] [RQ11]
				next_st.prescale[i] = '0;
			end
			else if (st.prescale[i] == TICK_LAST)
			begin
				// Minute tick: add one, saturating at the top. [RQ1] [RQ8]
				next_st.prescale[i] = '0;
				if (st.minutes[i] != ohc_pkg::OHC_MIN_MAX)
				begin
					next_st.minutes[i] = st.minutes[i] + 26'h0000001;
				end
			end
			else
			begin
				// Prescaler advances only while enabled. [RQ11]
				next_st.prescale[i] = st.prescale[i] + 31'h00000001;
			end
			// Whole hours, remainder of minutes dropped. [RQ2]
			next_st.hours[i] = ohc_pkg::OHC_HRS_W'(next_st.minutes[i] /
				ohc_pkg::OHC_MIN_PER_HOUR);
			// Contact follows hours against the user setpoint. [RQ5] [RQ9]
			next_st.contact[i] = (32'(st.hours[i]) >= upper_hours_setpoint[i]);
			next_st.clr_prev[i] = hours_clear_input[i];
			// Events: contact closing and clear input rising.
			ev[ohc_pkg::OHC_EV_LIMIT_LSB + i] = next_st.contact[i] &
				~st.contact[i];
			ev[ohc_pkg::OHC_EV_CLEAR_LSB + i] = hours_clear_input[i] &
				~st.clr_prev[i];
		end

		// Restore lasts one cycle after reset release.
		case (st.phase)
			ohc_pkg::OHC_RESTORE:
			begin
				next_st.phase = ohc_pkg::OHC_RUN;
			end
			ohc_pkg::OHC_RUN:
			begin
				next_st.phase = ohc_pkg::OHC_RUN;
			end
			default:
			begin
				next_st.phase = ohc_pkg::OHC_RESTORE;
			end
		endcase

		// Read data is captured in the setup cycle of a read.
		if (apb_setup && !apb_req.pwrite)
		begin
			next_st.rdata = '0;
			if (apb_req.paddr <= ohc_pkg::OHC_INST_END)
			begin
				if (ofs == ohc_pkg::OHC_OFS_HOURS)
				begin
					next_st.rdata = 32'(st.hours[idx]);
				end
				else if (ofs == ohc_pkg::OHC_OFS_MINUTES)
				begin
					next_st.rdata = 32'(st.minutes[idx]);
				end
				else if (ofs == ohc_pkg::OHC_OFS_SETPOINT)
				begin
					next_st.rdata = upper_hours_setpoint[idx];
				end
			end
			else if (apb_req.paddr == ohc_pkg::OHC_ADDR_CTRL)
			begin
				next_st.rdata = 32'(st.ctrl);
			end
			else if (apb_req.paddr == ohc_pkg::OHC_ADDR_STATUS)
			begin
				next_st.rdata = 32'(st.status);
			end
			else if (apb_req.paddr == ohc_pkg::OHC_ADDR_MASK)
			begin
				next_st.rdata = 32'(st.mask);
			end
		end

		// Writes and the read-clear of status take effect at access end.
		if (apb_access)
		begin
			if (apb_req.pwrite && apb_req.paddr == ohc_pkg::OHC_ADDR_CTRL)
			begin
				next_st.ctrl = apb_req.pwdata[ohc_pkg::OHC_NUM-1:0];
			end
			else if (apb_req.pwrite && apb_req.paddr == ohc_pkg::OHC_ADDR_MASK)
			begin
				next_st.mask = apb_req.pwdata[ohc_pkg::OHC_EV_W-1:0];
			end
			else if (!apb_req.pwrite &&
				apb_req.paddr == ohc_pkg::OHC_ADDR_STATUS)
			begin
				// Only bits that were actually returned get cleared.
				rd_clr = st.rdata[ohc_pkg::OHC_EV_W-1:0];
			end
		end

		// A new event beats a clear in the same cycle.
		next_st.status = (st.status & ~rd_clr) | ev;
		next_st.irq = |(next_st.status & next_st.mask);
	end

	// Registers the state; reset puts it into the restore phase.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st <= '0;
			st.phase <= ohc_pkg::OHC_RESTORE;
			st.ctrl <= ohc_pkg::OHC_CTRL_RST;
			st.mask <= ohc_pkg::OHC_MASK_RST;
		end
		else
		begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------

	// User-facing contact and hours value, both from registers.
	assign limit_reached_contact = st.contact;
	assign hours_value_output = st.hours;
	// Retained store image; valid once restore is done. [RQ3]
	assign retained_minutes_out = st.minutes;
	assign retained_valid = (st.phase == ohc_pkg::OHC_RUN);
	// APB answer: zero wait states, error on unmapped addresses.
	assign apb_rsp.prdata = st.rdata;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = apb_access & ~ohc_mapped(apb_req.paddr);
	assign irq = st.irq;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------

	// Per-instance checks on counting, clearing and the contact.
	for (genvar g = 0; g < ohc_pkg::OHC_NUM; g++)
	begin : g_chk
		chk_count_step: assert property ( // [RQ1]
			@(posedge clk) disable iff (srst)
			(st.phase == ohc_pkg::OHC_RUN && cnt_en[g] &&
			!hours_clear_input[g] && st.prescale[g] == TICK_LAST &&
			st.minutes[g] != ohc_pkg::OHC_MIN_MAX)
			|=> (st.minutes[g] == $past(st.minutes[g]) + 26'h0000001))
			else $error("minute tick did not add one");
		chk_hold_idle: assert property ( // [RQ1]
			@(posedge clk) disable iff (srst)
			(st.phase == ohc_pkg::OHC_RUN && !cnt_en[g] &&
			!hours_clear_input[g]) |=> $stable(st.minutes[g]))
			else $error("count moved while disabled");
		chk_hours_trunc: assert property ( // [RQ2]
			@(posedge clk) disable iff (srst)
			hours_value_output[g] == ohc_pkg::OHC_HRS_W'(st.minutes[g] /
			ohc_pkg::OHC_MIN_PER_HOUR))
			else $error("hours value not minutes over sixty");
		chk_clear_zero: assert property ( // [RQ12]
			@(posedge clk) disable iff (srst)
			(st.phase == ohc_pkg::OHC_RUN && hours_clear_input[g])
			|=> (st.minutes[g] == '0 && st.prescale[g] == '0))
			else $error("clear did not zero the counter");
		chk_limit_contact: assert property ( // [RQ5]
			@(posedge clk) disable iff (srst)
			st.phase == ohc_pkg::OHC_RUN ##1 1'b1 |->
			limit_reached_contact[g] ==
			(32'($past(st.hours[g])) >= $past(upper_hours_setpoint[g])))
			else $error("contact disagrees with setpoint compare");
		chk_drop_partial: assert property ( // [RQ7]
			@(posedge clk) disable iff (srst)
			$fell(cnt_en[g]) |=> (st.prescale[g] == '0))
			else $error("partial minute carried after enable drop");
		chk_restore_load: assert property ( // [RQ3]
			@(posedge clk) disable iff (srst)
			(!srst && st.phase == ohc_pkg::OHC_RESTORE) |=>
			(st.minutes[g] == $past(retained_minutes_in[g]) &&
			retained_valid))
			else $error("retained count not restored");
		// A closing contact leaves a sticky event in the same cycle.
		chk_limit_event: assert property ( // [RQ5]
			@(posedge clk) disable iff (srst)
			$rose(limit_reached_contact[g]) |->
			st.status[ohc_pkg::OHC_EV_LIMIT_LSB + g])
			else $error("contact closing left no event");
		// A rising clear coil leaves a sticky event one cycle later.
		chk_clear_event: assert property ( // [RQ4]
			@(posedge clk) disable iff (srst)
			(!srst && $rose(hours_clear_input[g])) |=>
			st.status[ohc_pkg::OHC_EV_CLEAR_LSB + g])
			else $error("clear rising left no event");
		// The prescaler never counts past the last cycle of a minute.
		chk_prescale_bound: assert property ( // [RQ11]
			@(posedge clk) disable iff (srst)
			st.prescale[g] <= TICK_LAST)
			else $error("prescaler ran past one minute");
		// Minutes move only on a tick, a clear or a restore.
		chk_tick_only: assert property ( // [RQ11]
			@(posedge clk) disable iff (srst)
			(!srst && st.phase == ohc_pkg::OHC_RUN &&
			!hours_clear_input[g] && st.prescale[g] != TICK_LAST)
			|=> $stable(st.minutes[g]))
			else $error("count moved between minute ticks");
	end

	// Interrupt level tracks unmasked sticky events.
	chk_irq_level: assert property ( // [RQ10]
		@(posedge clk) disable iff (srst)
		irq == |(st.status & st.mask))
		else $error("interrupt level wrong");

	// Sticky events stay set until software reads the status word.
	chk_status_sticky: assert property ( // [RQ5]
		@(posedge clk) disable iff (srst)
		!(apb_access && !apb_req.pwrite &&
		apb_req.paddr == ohc_pkg::OHC_ADDR_STATUS) |=>
		((st.status & $past(st.status)) == $past(st.status)))
		else $error("event bit lost without a status read");

endmodule

`default_nettype wire

// File: testbench/ohc_store_model.sv
/*
 * Retained store model: the nonvolatile copy of the minute counts.
 * Assumes the block restores from it in the first cycle after reset.
 */
`timescale 1ns/10ps
`default_nettype none

module ohc_store_model
#(
	parameter ohc_pkg::ohc_min_arr_t PRELOAD = '0
)
(
	input wire logic clk,
	input wire ohc_pkg::ohc_min_arr_t retained_minutes_out,
	input wire logic retained_valid,
	output ohc_pkg::ohc_min_arr_t retained_minutes_in
);

	// ----------
	// Storage
	// ----------

	// Saved counts; they start from the preload as after power returns.
	ohc_pkg::ohc_min_arr_t store = PRELOAD;

	// Saves only while valid, so a reset never writes zeros in.
	always_ff @(posedge clk)
	begin
		if (retained_valid)
		begin
			store <= retained_minutes_out;
		end
	end

	// Presents the saved counts for the restore cycle.
	assign retained_minutes_in = store;

endmodule
`default_nettype wire

// File: testbench/tb_top.sv
/*
 * Self-checking bench for the operating hours counter block.
 * Assumes a four-cycle minute and the retained store model beside it.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;

	// ----------
	// Signals
	// ----------

	localparam int unsigned MC = 4; // Cycles per minute tick.
	logic clk = 1'b0; // System clock.
	logic srst = 1'b1; // Synchronous reset.
	logic [3:0] en = '0; // Enable coils.
	logic [3:0] clr = '0; // Clear coils.
	// Setpoints in hours, one exactly at the restored hours.
	ohc_pkg::ohc_set_arr_t setp = {32'h000D5DE0, 32'hFFFFFFFF,
		32'h00000001, 32'h00000002};
	logic [3:0] contact; // Limit contacts.
	ohc_pkg::ohc_hrs_arr_t hours; // Hours outputs.
	ohc_pkg::ohc_min_arr_t r_in; // Store to block.
	ohc_pkg::ohc_min_arr_t r_out; // Block to store.
	logic r_valid; // Store may save.
	ohc_pkg::ohc_apb_req_t req = '0; // Bus request.
	ohc_pkg::ohc_apb_rsp_t rsp; // Bus answer.
	logic irq; // Interrupt line.
	logic [33:0] expq[$]; // Notes: check data, error, data.
	logic [33:0] note; // Note being compared.
	int num_errors = 0; // Mismatches.
	int n_compared = 0; // Comparisons.
	logic [7:0] lfsr = 8'h07; // Random state.
	int k; // Random minute count.
	logic [25:0] mins[4] = '{26'h0, 26'h0, 26'h0, 26'h3220080};

	ohc_top #(.MINUTE_CYCLES(MC)) dut (.clk(clk), .srst(srst),
		.hours_count_enable(en), .hours_clear_input(clr),
		.upper_hours_setpoint(setp), .limit_reached_contact(contact),
		.hours_value_output(hours), .retained_minutes_in(r_in),
		.retained_minutes_out(r_out), .retained_valid(r_valid),
		.apb_req(req), .apb_rsp(rsp), .irq(irq));

	// One hundred years of minutes waits in the store for instance 3.
	ohc_store_model #(.PRELOAD({26'h3220080, 78'h0})) store (.clk(clk),
		.retained_minutes_out(r_out), .retained_valid(r_valid),
		.retained_minutes_in(r_in));

	// Clock of 40 ns.
	initial
	begin
		forever #20 clk = ~clk;
	end

	// ----------
	// Tasks
	// ----------

	// Next value of the random sequence.
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// Prints the verdict and ends the run.
	task automatic finish_test();
		if (num_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Compares a settled output at the falling edge; the output is read
	// there, not when the task is called: 0 hours, 1 contacts, 2 irq.
	task automatic chk(input int sel, input int i, input logic [31:0] exp);
		logic [31:0] got;
		@(negedge clk);
		case (sel)
			0: got = 32'(hours[i]);
			1: got = 32'(contact);
			default: got = 32'(irq);
		endcase
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
		@(posedge clk);
	endtask

	// One bus transfer; its expected answer goes on the queue.
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, input logic [33:0] exp);
		int n;
		n = 0;
		expq.push_back(exp);
		req.paddr <= a;
		req.pwrite <= w;
		req.pwdata <= d;
		req.psel <= 1'b1;
		@(posedge clk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			num_errors++;
			finish_test();
		end
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk);
	endtask

	// Holds chosen enable coils high for a number of cycles.
	task automatic run(input logic [3:0] m, input int cyc);
		en <= m;
		repeat (cyc) @(posedge clk);
		en <= '0;
		repeat (3) @(posedge clk);
	endtask

	// Takes the oldest note off the queue at each finished transfer.
	always @(posedge clk)
	begin
		if (req.psel && req.penable && rsp.pready === 1'b1)
		begin
			note = expq.pop_front();
			n_compared++;
			if (rsp.pslverr !== note[32] ||
				(note[33] && rsp.prdata !== note[31:0]))
			begin
				num_errors++;
				$display("Error at %0t: bus answer %h", $time, rsp.prdata);
			end
		end
	end

	// ----------
	// Scenarios
	// ----------

	// Main sequence.
	initial
	begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(0, 3, 32'h000D5DE0);
		chk(1, 0, 32'h00000008);
		apb(8'h40, 1'b0, '0, {2'b10, 32'h0000000F});
		apb(8'h48, 1'b0, '0, {2'b10, 32'h00000000});
		apb(8'h30, 1'b1, 32'h00000005, {2'b00, 32'h0});
		apb(8'h30, 1'b0, '0, {2'b10, 32'h000D5DE0});
		apb(8'h4C, 1'b0, '0, {2'b11, 32'h00000000});
		apb(8'h0C, 1'b1, 32'h00000001, {2'b01, 32'h0});
		chk(2, 0, 32'h00000000);
		apb(8'h48, 1'b1, 32'h00000008, {2'b00, 32'h0});
		chk(2, 0, 32'h00000001);
		apb(8'h44, 1'b0, '0, {2'b10, 32'h00000008});
		chk(2, 0, 32'h00000000);
		// Random whole minutes on single instances, then a split minute.
		for (int i = 0; i < 3; i++)
		begin
			lfsr = lfsr_next(lfsr);
			k = int'(lfsr % 3) + 1;
			run(4'(1 << i), MC * k);
			mins[i] += 26'(k);
		end
		run(4'h1, MC - 1);
		run(4'h1, MC - 1);
		run(4'h2, MC * 60);
		mins[1] += 26'h3C;
		run(4'hF, MC);
		for (int i = 0; i < 4; i++)
		begin
			mins[i] += 26'h1;
			apb(8'(16 * i + 4), 1'b0, '0, {2'b10, 32'(mins[i])});
			chk(0, i, 32'(mins[i] / 26'h3C));
		end
		chk(1, 0, 32'h0000000A);
		setp[0] <= 32'h00000000;
		setp[3] <= 32'h000D5DE1;
		repeat (3) @(posedge clk);
		chk(1, 0, 32'h00000003);
		apb(8'h38, 1'b0, '0, {2'b10, 32'h000D5DE1});
		// A reset in mid-run keeps the counts.
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		chk(0, 1, 32'h00000001);
		apb(8'h14, 1'b0, '0, {2'b10, 32'(mins[1])});
		apb(8'h44, 1'b0, '0, {2'b10, 32'h00000003});
		// Clear wins over enable.
		clr <= 4'h2;
		run(4'h2, MC * 2);
		clr <= 4'h0;
		chk(0, 1, 32'h00000000);
		apb(8'h14, 1'b0, '0, {2'b10, 32'h00000000});
		apb(8'h44, 1'b0, '0, {2'b10, 32'h00000020});
		// A closed count gate stops instance 0.
		apb(8'h40, 1'b1, 32'h0000000E, {2'b00, 32'h0});
		run(4'h1, MC * 2);
		apb(8'h04, 1'b0, '0, {2'b10, 32'(mins[0])});
		finish_test();
	end

endmodule
`default_nettype wire
